// *** include/aga_defines.svh ***
`ifndef AGA_DEFINES_SVH
`define AGA_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define AGA_OFS_INSTR 8'h00
`define AGA_OFS_STATUS 8'h04
`define AGA_OFS_COND 8'h08
`define AGA_OFS_ACC 8'h0c
`define AGA_OFS_EXT 8'h10
`define AGA_OFS_IDX1 8'h14
`define AGA_OFS_IDX2 8'h18
`define AGA_OFS_IDX3 8'h1c

// ****************************************
// Instruction fields
// ****************************************
`define AGA_OPC_HI 23
`define AGA_OPC_LO 18
`define AGA_IND_BIT 17
`define AGA_IDX_HI 16
`define AGA_IDX_LO 15
`define AGA_ADR_HI 14
`define AGA_SIGN_BIT 23
`define AGA_IMM_HI 7

// ****************************************
// Opcodes
// ****************************************
`define AGA_OP_INC_MEM 6'h18
`define AGA_OP_MEM_TO_IDX 6'h21
`define AGA_OP_MEM_TO_EXT 6'h22
`define AGA_OP_MEM_TO_ACC 6'h23
`define AGA_OP_MEM_TO_DBL 6'h24
`define AGA_OP_MEM_TO_BYTE 6'h25
`define AGA_OP_IDX_TO_MEM 6'h26
`define AGA_OP_EXT_TO_MEM 6'h27
`define AGA_OP_ACC_TO_MEM 6'h28
`define AGA_OP_IMM_TO_BYTE 12'h00a

// ****************************************
// Condition bits and reset values
// ****************************************
`define AGA_C_POS 3
`define AGA_C_ZERO 2
`define AGA_C_NEG 1
`define AGA_C_OVF 0
`define AGA_RST_WORD 24'h000000
`define AGA_RST_COND 4'h0

// ****************************************
// Bus responses
// ****************************************
`define AGA_RESP_OKAY 2'h0
`define AGA_RESP_SLVERR 2'h2

`endif

// *** include/aga_pkg.sv ***
package aga_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_INDIRECT,
    ST_READ_OP,
    ST_READ_OP2,
    ST_CALC,
    ST_WRITE,
    ST_COMMIT
  } aga_state_t;

  typedef struct packed {
    logic we;
    logic [14:0] addr;
    logic [23:0] wdata;
  } aga_mem_req_t;

  typedef struct packed {
    logic pos;
    logic zero;
    logic neg;
    logic ovf;
  } aga_cond_t;

endpackage

// *** logic/aga_add_unit.sv ***
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "aga_defines.svh"

// Behaviour
// - negative flag bit 1 when result below zero
// - overflow bit 0 on carry-in xor carry-out
// - single-word sign bit is bit 23
// - each add updates positive, negative, zero
// - opcode 30 increments memory word, writes back
// - opcode 41 adds memory into selected index
// - select 1, 2, 3 picks first, second, third index
// - select ops skip direct indexing, index indirect
// - opcode 43 adds memory into accumulator
// - opcode 42 adds memory into extension
// - opcode 44 double add, flags from double
// - opcode 45 adds memory byte to low byte
// - opcode 46 adds full index into memory
// - opcode 50 adds accumulator into memory
// - opcode 47 adds extension into memory
// - opcode 0012 adds signed immediate to byte
// - positive flag bit 3 when result above zero
// - zero flag bit 2 when all bits zero
// - double is extension joined with accumulator
module aga_add_unit (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output aga_pkg::aga_mem_req_t MEM_REQ,
  output logic MEM_VALID,
  input wire logic MEM_ACK,
  input wire logic [23:0] MEM_RDATA,
  output logic BUSY
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic ovf_of(input logic a_s, input logic b_s, input logic r_s);
    ovf_of = (a_s == b_s) && (r_s != a_s);
  endfunction

  function automatic aga_pkg::aga_cond_t cond_of(input logic neg, input logic zero,
                                                 input logic ovf);
    aga_pkg::aga_cond_t c;
    c.neg = neg;
    c.zero = zero;
    c.pos = !neg && !zero;
    c.ovf = ovf;
    cond_of = c;
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge_strb = m;
  endfunction

  // ****************************************
  // Storage
  // ****************************************
  aga_pkg::aga_state_t state_r;
  logic [23:0] instr_r;
  logic [23:0] acc_r;
  logic [23:0] ext_r;
  logic [23:0] idx_r [1:3];
  aga_pkg::aga_cond_t cond_r;
  logic illegal_r;
  logic [23:0] mem1_r;
  logic [23:0] mem2_r;
  logic [47:0] res_r;
  aga_pkg::aga_cond_t res_cond_r;
  logic [14:0] ea_r;
  aga_pkg::aga_mem_req_t mem_r;
  logic mem_valid_r;

  logic aw_have_r;
  logic w_have_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  logic [5:0] opc;
  logic [1:0] xsel;
  logic do_write;
  logic wr_hit;
  logic start;

  assign opc = instr_r[`AGA_OPC_HI:`AGA_OPC_LO];
  assign xsel = instr_r[`AGA_IDX_HI:`AGA_IDX_LO];

  function automatic logic [23:0] idx_of(input logic [1:0] sel, input logic [23:0] i1,
                                         input logic [23:0] i2, input logic [23:0] i3);
    if (sel == 2'h1) begin
      idx_of = i1;
    end else if (sel == 2'h2) begin
      idx_of = i2;
    end else if (sel == 2'h3) begin
      idx_of = i3;
    end else begin
      idx_of = 24'h000000;
    end
  endfunction

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign S_AXI_AWREADY = !aw_have_r;
  assign S_AXI_WREADY = !w_have_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign do_write = aw_have_r && w_have_r && !bvalid_r;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `AGA_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && !aw_have_r) begin
        aw_have_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_have_r) begin
        w_have_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `AGA_RESP_OKAY : `AGA_RESP_SLVERR;
      end else if (bvalid_r && S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_hit = 1'b0;
    if (awaddr_r == `AGA_OFS_INSTR) begin
      wr_hit = 1'b1;
    end else if (awaddr_r == `AGA_OFS_COND || awaddr_r == `AGA_OFS_ACC) begin
      wr_hit = 1'b1;
    end else if (awaddr_r == `AGA_OFS_EXT || awaddr_r == `AGA_OFS_IDX1) begin
      wr_hit = 1'b1;
    end else if (awaddr_r == `AGA_OFS_IDX2 || awaddr_r == `AGA_OFS_IDX3) begin
      wr_hit = 1'b1;
    end
  end

  // Instruction write while idle launches execution
  assign start = do_write && awaddr_r == `AGA_OFS_INSTR && state_r == aga_pkg::ST_IDLE;

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `AGA_RESP_OKAY;
    end else if (S_AXI_ARVALID && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rresp_r <= `AGA_RESP_OKAY;
      if (S_AXI_ARADDR == `AGA_OFS_INSTR) begin
        rdata_r <= {8'h00, instr_r};
      end else if (S_AXI_ARADDR == `AGA_OFS_STATUS) begin
        rdata_r <= {30'h00000000, illegal_r, BUSY};
      end else if (S_AXI_ARADDR == `AGA_OFS_COND) begin
        rdata_r <= {28'h0000000, cond_r};
      end else if (S_AXI_ARADDR == `AGA_OFS_ACC) begin
        rdata_r <= {8'h00, acc_r};
      end else if (S_AXI_ARADDR == `AGA_OFS_EXT) begin
        rdata_r <= {8'h00, ext_r};
      end else if (S_AXI_ARADDR == `AGA_OFS_IDX1) begin
        rdata_r <= {8'h00, idx_r[1]};
      end else if (S_AXI_ARADDR == `AGA_OFS_IDX2) begin
        rdata_r <= {8'h00, idx_r[2]};
      end else if (S_AXI_ARADDR == `AGA_OFS_IDX3) begin
        rdata_r <= {8'h00, idx_r[3]};
      end else begin
        rdata_r <= 32'h00000000;
        rresp_r <= `AGA_RESP_SLVERR;
      end
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // ****************************************
  // Arithmetic
  // ****************************************
  logic [23:0] opnd_b;
  logic [23:0] sum24;
  logic [7:0] byte_a;
  logic [7:0] sum8;
  logic [47:0] dbl_a;
  logic [47:0] dbl_b;
  logic [47:0] sum48;
  logic [47:0] res_nxt;
  aga_pkg::aga_cond_t cond_nxt;
  logic is_imm;

  assign is_imm = instr_r[23:12] == `AGA_OP_IMM_TO_BYTE;

  always_comb begin
    opnd_b = acc_r;
    if (opc == `AGA_OP_INC_MEM) begin
      opnd_b = 24'h000001;
    end else if (opc == `AGA_OP_MEM_TO_IDX || opc == `AGA_OP_IDX_TO_MEM) begin
      opnd_b = idx_of(xsel, idx_r[1], idx_r[2], idx_r[3]);
    end else if (opc == `AGA_OP_MEM_TO_EXT || opc == `AGA_OP_EXT_TO_MEM) begin
      opnd_b = ext_r;
    end
    sum24 = mem1_r + opnd_b;
    byte_a = is_imm ? instr_r[`AGA_IMM_HI:0] : mem1_r[7:0];
    sum8 = byte_a + acc_r[7:0];
    dbl_a = {mem1_r, mem2_r};
    dbl_b = {ext_r, acc_r};
    sum48 = dbl_a + dbl_b;
    if (is_imm || opc == `AGA_OP_MEM_TO_BYTE) begin
      res_nxt = {24'h000000, acc_r[23:8], sum8};
      cond_nxt = cond_of(sum8[7], sum8 == 8'h00, ovf_of(byte_a[7], acc_r[7], sum8[7]));
    end else if (opc == `AGA_OP_MEM_TO_DBL) begin
      res_nxt = sum48;
      cond_nxt = cond_of(sum48[47], sum48 == 48'h000000000000,
                         ovf_of(dbl_a[47], dbl_b[47], sum48[47]));
    end else begin
      res_nxt = {24'h000000, sum24};
      cond_nxt = cond_of(sum24[`AGA_SIGN_BIT], sum24 == 24'h000000,
                         ovf_of(mem1_r[`AGA_SIGN_BIT], opnd_b[`AGA_SIGN_BIT],
                                sum24[`AGA_SIGN_BIT]));
    end
  end

  // ****************************************
  // Instruction sequencer
  // ****************************************
  logic legal;
  logic writes_mem;
  logic sel_op;
  logic [14:0] direct_ea;
  logic [14:0] ind_ea;

  always_comb begin
    sel_op = opc == `AGA_OP_MEM_TO_IDX || opc == `AGA_OP_IDX_TO_MEM;
    writes_mem = opc == `AGA_OP_INC_MEM || opc == `AGA_OP_IDX_TO_MEM ||
                 opc == `AGA_OP_EXT_TO_MEM || opc == `AGA_OP_ACC_TO_MEM;
    legal = (opc >= `AGA_OP_MEM_TO_IDX && opc <= `AGA_OP_ACC_TO_MEM) ||
            opc == `AGA_OP_INC_MEM;
    if (sel_op && xsel == 2'h0) begin
      legal = 1'b0;
    end
    // Select ops use the field as a register choice, not an index
    direct_ea = instr_r[`AGA_ADR_HI:0] +
                (sel_op ? 15'h0000 : 15'(idx_of(xsel, idx_r[1], idx_r[2], idx_r[3])));
    ind_ea = MEM_RDATA[`AGA_ADR_HI:0] +
             15'(idx_of(MEM_RDATA[`AGA_IDX_HI:`AGA_IDX_LO], idx_r[1], idx_r[2],
                        idx_r[3]));
  end

  assign BUSY = state_r != aga_pkg::ST_IDLE;
  assign MEM_REQ = mem_r;
  assign MEM_VALID = mem_valid_r;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r <= aga_pkg::ST_IDLE;
      instr_r <= `AGA_RST_WORD;
      illegal_r <= 1'b0;
      mem1_r <= `AGA_RST_WORD;
      mem2_r <= `AGA_RST_WORD;
      res_r <= 48'h000000000000;
      res_cond_r <= `AGA_RST_COND;
      ea_r <= 15'h0000;
      mem_r <= '0;
      mem_valid_r <= 1'b0;
    end else begin
      case (state_r)
        aga_pkg::ST_IDLE: begin
          if (start) begin
            instr_r <= wdata_r[23:0];
            illegal_r <= 1'b0;
            if (wdata_r[23:12] == `AGA_OP_IMM_TO_BYTE) begin
              state_r <= aga_pkg::ST_CALC;
            end else begin
              state_r <= aga_pkg::ST_INDIRECT;
            end
          end
        end
        aga_pkg::ST_INDIRECT: begin
          if (!mem_valid_r) begin
            // First reference at the direct address
            mem_r <= '{we: 1'b0, addr: direct_ea, wdata: `AGA_RST_WORD};
            mem_valid_r <= 1'b1;
            ea_r <= direct_ea;
            if (!instr_r[`AGA_IND_BIT]) begin
              state_r <= aga_pkg::ST_READ_OP;
            end
          end else if (MEM_ACK) begin
            mem_r.addr <= ind_ea;
            if (!MEM_RDATA[`AGA_IND_BIT]) begin
              ea_r <= ind_ea;
              state_r <= aga_pkg::ST_READ_OP;
            end
          end
        end
        aga_pkg::ST_READ_OP: begin
          if (MEM_ACK) begin
            mem1_r <= MEM_RDATA;
            if (opc == `AGA_OP_MEM_TO_DBL) begin
              mem_r.addr <= ea_r + 15'h0001;
              state_r <= aga_pkg::ST_READ_OP2;
            end else begin
              mem_valid_r <= 1'b0;
              state_r <= aga_pkg::ST_CALC;
            end
          end
        end
        aga_pkg::ST_READ_OP2: begin
          if (MEM_ACK) begin
            mem2_r <= MEM_RDATA;
            mem_valid_r <= 1'b0;
            state_r <= aga_pkg::ST_CALC;
          end
        end
        aga_pkg::ST_CALC: begin
          res_r <= res_nxt;
          res_cond_r <= cond_nxt;
          illegal_r <= !legal && !is_imm;
          if (writes_mem) begin
            mem_r <= '{we: 1'b1, addr: ea_r, wdata: res_nxt[23:0]};
            mem_valid_r <= 1'b1;
            state_r <= aga_pkg::ST_WRITE;
          end else begin
            state_r <= aga_pkg::ST_COMMIT;
          end
        end
        aga_pkg::ST_WRITE: begin
          if (MEM_ACK) begin
            mem_valid_r <= 1'b0;
            mem_r.we <= 1'b0;
            state_r <= aga_pkg::ST_COMMIT;
          end
        end
        default: begin
          state_r <= aga_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Working registers and condition
  // ****************************************
  logic [31:0] wmerge;

  assign wmerge = merge_strb(32'h00000000, wdata_r, wstrb_r);

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      acc_r <= `AGA_RST_WORD;
      ext_r <= `AGA_RST_WORD;
      idx_r[1] <= `AGA_RST_WORD;
      idx_r[2] <= `AGA_RST_WORD;
      idx_r[3] <= `AGA_RST_WORD;
      cond_r <= `AGA_RST_COND;
    end else if (state_r == aga_pkg::ST_COMMIT) begin
      cond_r <= res_cond_r;
      if (is_imm || opc == `AGA_OP_MEM_TO_BYTE || opc == `AGA_OP_MEM_TO_ACC) begin
        acc_r <= res_r[23:0];
      end else if (opc == `AGA_OP_MEM_TO_EXT) begin
        ext_r <= res_r[23:0];
      end else if (opc == `AGA_OP_MEM_TO_DBL) begin
        ext_r <= res_r[47:24];
        acc_r <= res_r[23:0];
      end else if (opc == `AGA_OP_MEM_TO_IDX) begin
        idx_r[xsel] <= res_r[23:0];
      end
    end else if (do_write && state_r == aga_pkg::ST_IDLE) begin
      if (awaddr_r == `AGA_OFS_COND) begin
        cond_r <= 4'(merge_strb({28'h0000000, cond_r}, wdata_r, wstrb_r));
      end else if (awaddr_r == `AGA_OFS_ACC) begin
        acc_r <= 24'(merge_strb({8'h00, acc_r}, wmerge, wstrb_r));
      end else if (awaddr_r == `AGA_OFS_EXT) begin
        ext_r <= 24'(merge_strb({8'h00, ext_r}, wdata_r, wstrb_r));
      end else if (awaddr_r == `AGA_OFS_IDX1) begin
        idx_r[1] <= 24'(merge_strb({8'h00, idx_r[1]}, wdata_r, wstrb_r));
      end else if (awaddr_r == `AGA_OFS_IDX2) begin
        idx_r[2] <= 24'(merge_strb({8'h00, idx_r[2]}, wdata_r, wstrb_r));
      end else if (awaddr_r == `AGA_OFS_IDX3) begin
        idx_r[3] <= 24'(merge_strb({8'h00, idx_r[3]}, wdata_r, wstrb_r));
      end
    end
  end

endmodule

// *** verification/aga_add_chk.sv ***
`timescale 1ns/10ps
module aga_add_chk (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input aga_pkg::aga_mem_req_t MEM_REQ,
  input wire logic MEM_VALID,
  input wire logic MEM_ACK,
  input wire logic BUSY
);
  // ********
  // Address of the last operand read
  // ********
  logic [14:0] rd_addr_r;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_addr_r <= 15'h0000;
    end else if (MEM_VALID && MEM_ACK && !MEM_REQ.we) begin
      rd_addr_r <= MEM_REQ.addr;
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  a_req_stable: assert property (MEM_VALID && !MEM_ACK |=> MEM_VALID && $stable(MEM_REQ))
    else $error("Memory request moved before ack");
  a_wb_addr: assert property (MEM_VALID && MEM_REQ.we |-> MEM_REQ.addr == rd_addr_r)
    else $error("Write-back address differs from operand address");
  a_mem_busy: assert property (MEM_VALID |-> BUSY)
    else $error("Memory request while idle");
  a_busy_start: assert property ($rose(BUSY) |-> S_AXI_BVALID)
    else $error("Busy without an instruction write");
  a_busy_ends: assert property ($rose(BUSY) |-> ##[1:300] !BUSY)
    else $error("Instruction never completed");
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("Write response dropped");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("Read data dropped");
  a_slverr_zero: assert property (S_AXI_RVALID && S_AXI_RRESP == 2'h2 |-> S_AXI_RDATA == 32'h0)
    else $error("Refused read returned data");
  cover property (MEM_VALID && MEM_ACK && MEM_REQ.we);
  cover property ($fell(BUSY));
  cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
endmodule

bind aga_add_unit aga_add_chk aga_add_chk_i (
  .REF_CLK(REF_CLK), .ARST_N(ARST_N), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .MEM_REQ(MEM_REQ),
  .MEM_VALID(MEM_VALID), .MEM_ACK(MEM_ACK), .BUSY(BUSY)
);

// *** verification/aga_mem_model.sv ***
`timescale 1ns/10ps
module aga_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input aga_pkg::aga_mem_req_t req,
  input wire logic valid,
  output logic ack,
  output logic [23:0] rdata
);
  logic [23:0] mem [0:32767];
  int wait_r;
  initial begin
    ack = 1'b0;
    rdata = 24'h5a5a5a;
  end
  // Random answer delay; data toggles outside the answer cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      wait_r <= 0;
    end else begin
      ack <= 1'b0;
      rdata <= ~rdata;
      if (valid && !ack) begin
        if (wait_r == 0) begin
          ack <= 1'b1;
          wait_r <= $urandom_range(0, 3);
          if (req.we) mem[req.addr] <= req.wdata;
          else rdata <= mem[req.addr];
        end else begin
          wait_r <= wait_r - 1;
        end
      end
    end
  end
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module tb_top;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, busy, mem_valid, mem_ack;
  logic [1:0] bresp, rresp;
  logic [23:0] mem_rdata, acc, ext, m, m2, exp_mem;
  logic [23:0] ix [1:3];
  logic [3:0] ef;
  aga_pkg::aga_mem_req_t mem_req;
  int n_fail = 0, check_count = 0;
  logic [23:0] bnd [4] = '{24'h7fffff, 24'hffffff, 24'h000000, 24'h800000};
  logic [5:0] optab [10] = '{6'h18, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h00};
  always #20 ref_clk = ~ref_clk;
  aga_add_unit aga_add_unit_i (.REF_CLK(ref_clk), .ARST_N(arst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .MEM_REQ(mem_req), .MEM_VALID(mem_valid), .MEM_ACK(mem_ack),
    .MEM_RDATA(mem_rdata), .BUSY(busy));
  aga_mem_model aga_mem_model_i (.clk(ref_clk), .rst_n(arst_n), .req(mem_req),
    .valid(mem_valid), .ack(mem_ack), .rdata(mem_rdata));
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic fail_to;
    n_fail++;
    $display("BAD %0t wait ran out", $time);
    give_verdict();
  endtask
  // Handshakes judged mid-cycle, acted on right after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw_hs, w_hs, b_hs;
    n = 0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'($urandom_range(0, 1));
    do begin
      @(negedge ref_clk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid && bready;
      r = bresp;
      @(posedge ref_clk);
      n++;
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (!b_hs) bready <= 1'b1;
    end while (!b_hs && n < 100);
    if (n >= 100) fail_to();
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_hs, r_hs;
    n = 0;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'($urandom_range(0, 1));
    do begin
      @(negedge ref_clk);
      ar_hs = arvalid && arready;
      r_hs = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge ref_clk);
      n++;
      if (ar_hs) arvalid <= 1'b0;
      if (!r_hs) rready <= 1'b1;
    end while (!r_hs && n < 100);
    if (n >= 100) fail_to();
    rready <= 1'b0;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [23:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK({r, d}, {2'h0, 8'h00, e});
  endtask
  // Sum of w-bit values, flags into ef
  function automatic longint sm(longint a, longint b, int w);
    longint r;
    longint s;
    r = (a + b) & ((64'd1 << w) - 1);
    s = 64'd1 << (w - 1);
    ef = {r != 0 && (r & s) == 0, r == 0, (r & s) != 0, (a & s) == (b & s) && (r & s) != (a & s)};
    return r;
  endfunction
  function automatic logic [23:0] rv();
    return ($urandom_range(0, 1) != 0) ? bnd[$urandom_range(0, 3)] : 24'($urandom);
  endfunction
  initial begin
    logic [31:0] d;
    logic [1:0] r, sel, isel;
    logic [5:0] op;
    logic [14:0] a0, ea, ia;
    logic [23:0] ins, b;
    logic ind, selop;
    int n;
    void'($urandom(89));
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (int i = 2; i < 8; i++) chk_reg(8'(4 * i), 24'h0);
    rd(8'h20, d, r);
    `CHK({r, d}, {2'h2, 32'h0});
    wr(8'h24, 32'h1, r);
    `CHK(r, 2'h2);
    for (int k = 0; k < 100; k++) begin
      op = optab[k % 10];
      selop = op == 6'h21 || op == 6'h26;
      ind = k[3];
      sel = selop ? 2'(1 + k % 3) : (ind ? 2'h0 : 2'($urandom_range(0, 3)));
      acc = rv();
      ext = rv();
      for (int i = 1; i < 4; i++) ix[i] = rv();
      a0 = 15'($urandom_range(0, 16'h3fff));
      isel = 2'($urandom_range(0, 3));
      ia = 15'($urandom_range(16'h4000, 16'h7ffe));
      ea = ind ? ia + (isel != 0 ? ix[isel][14:0] : 15'h0)
               : a0 + (sel != 0 && !selop ? ix[sel][14:0] : 15'h0);
      m = rv();
      m2 = rv();
      aga_mem_model_i.mem[a0] = {7'h00, isel, ia};
      aga_mem_model_i.mem[ea] = m;
      aga_mem_model_i.mem[15'(ea + 15'h1)] = m2;
      wr(8'h0c, {8'h0, acc}, r);
      wr(8'h10, {8'h0, ext}, r);
      for (int i = 1; i < 4; i++) wr(8'(16 + 4 * i), {8'h0, ix[i]}, r);
      b = rv();
      ins = op == 6'h00 ? {12'h00a, 4'h0, b[7:0]} : {op, ind, sel, a0};
      exp_mem = m;
      case (op)
        6'h18: exp_mem = 24'(sm(m, 1, 24));
        6'h21: ix[sel] = 24'(sm(ix[sel], m, 24));
        6'h22: ext = 24'(sm(ext, m, 24));
        6'h23: acc = 24'(sm(acc, m, 24));
        6'h24: {ext, acc} = 48'(sm({ext, acc}, {m, m2}, 48));
        6'h25: acc[7:0] = 8'(sm(acc[7:0], m[7:0], 8));
        6'h26: exp_mem = 24'(sm(m, ix[sel], 24));
        6'h27: exp_mem = 24'(sm(m, ext, 24));
        6'h28: exp_mem = 24'(sm(m, acc, 24));
        default: acc[7:0] = 8'(sm(acc[7:0], b[7:0], 8));
      endcase
      wr(8'h00, {8'h0, ins}, r);
      `CHK(r, 2'h0);
      if (op == 6'h24 && ind) begin
        wr(8'h00, {8'h0, 6'h18, 18'h0}, r);
        `CHK(r, 2'h0);
      end
      n = 0;
      while (busy !== 1'b0 && n < 300) begin
        @(posedge ref_clk);
        n++;
      end
      if (n >= 300) fail_to();
      rd(8'h08, d, r);
      `CHK(d, {28'h0, ef});
      chk_reg(8'h0c, acc);
      chk_reg(8'h10, ext);
      for (int i = 1; i < 4; i++) chk_reg(8'(16 + 4 * i), ix[i]);
      `CHK(aga_mem_model_i.mem[ea], exp_mem);
      rd(8'h04, d, r);
      `CHK(d[0], 1'b0);
    end
    give_verdict();
  end
endmodule
